// ### verilog/adc_ctrl_pkg.sv
// Purpose: constants for the converter control block
// Assumes: 25 MHz system clock, byte-wide register port
// Notes:   offsets are byte addresses on the register port
package adc_ctrl_pkg;
   // ********************************
   // register map
   // ********************************
   localparam logic [11:0] ADDR_CTL_PRIMARY   = 12'hF70;
   localparam logic [11:0] ADDR_CTL_SECONDARY = 12'hF71;
   localparam logic [11:0] ADDR_RESULT_HIGH   = 12'hF72;
   localparam logic [11:0] ADDR_RESULT_LOW    = 12'hF73;
   localparam logic [7:0]  RESET_PRIMARY      = 8'h00;
   localparam logic [7:0]  RESET_SECONDARY    = 8'h80;
   // primary fields
   localparam int BIT_GO       = 7;
   localparam int BIT_REF_LO   = 6;
   localparam int BIT_REF_PIN  = 5;
   localparam int BIT_REPEAT   = 4;
   // secondary fields
   localparam int BIT_REF_HI   = 7;
   // widths of the input and buffer code fields, both at the bottom of their byte
   localparam int SEL_W        = 4;
   localparam int BUF_W        = 3;
   // ********************************
   // timing, in system clock cycles
   // ********************************
   localparam int FIRST_CYCLES  = 5129;
   localparam int REPEAT_CYCLES = 256;
   localparam int COUNT_W       = 14;
   // ********************************
   // codes
   // ********************************
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_1V0      = 2'h1;
   localparam logic [1:0] REF_2V0      = 2'h2;
   localparam logic [3:0] SEL_GROUND   = 4'hC;
   localparam logic [3:0] SEL_TEMP     = 4'hE;
   localparam logic [3:0] SEL_DIFF_MAX = 4'hA;
   localparam logic [3:0] SEL_OFFSET   = 4'hF;
   localparam logic [2:0] BUF_SE_RAW   = 3'h0;
   localparam logic [2:0] BUF_SE_UNITY = 3'h1;
   localparam logic [2:0] BUF_DI_RAW   = 3'h4;
   localparam logic [2:0] BUF_DI_UNITY = 3'h5;
endpackage

// ### verilog/adc_input_decode.sv
// Purpose: input switch decoder for the analog multiplexer
// Assumes: codes already registered
// Notes:   registered outputs; one cycle behind the control bits
`timescale 1ns/1ps
module adc_input_decode
   import adc_ctrl_pkg::*;
(
   input  wire logic       clk_sys,     // system clock
   input  wire logic       rst,         // sync reset
   input  wire logic [3:0] inputSelect, // channel code
   input  wire logic [2:0] bufferSelect,// buffer mode code
   output logic [7:0]      posSwitch,   // pin to positive input
   output logic [7:0]      negSwitch,   // pin to negative input
   output logic            groundNodes, // ground pins 1 and 2
   output logic            tempSelect,  // temperature sensor
   output logic            offsetShort, // inputs shorted
   output logic            diffMode,    // differential path
   output logic            unityBuffer  // buffer on
);
   typedef struct packed {
      logic [7:0] pos;
      logic [7:0] neg;
      logic       gnd;
      logic       temp;
      logic       shrt;
      logic       diff;
      logic       unity;
   } dec_t;
   dec_t decReg, decNext;
   // diff pair table, index by code, {pos,neg}
   function automatic logic [5:0] pairOf(input logic [3:0] c);
      unique case (c)
         4'h0: pairOf = {3'h0, 3'h1};
         4'h1: pairOf = {3'h2, 3'h3};
         4'h2: pairOf = {3'h4, 3'h5};
         4'h3: pairOf = {3'h1, 3'h0};
         4'h4: pairOf = {3'h3, 3'h2};
         4'h5: pairOf = {3'h5, 3'h4};
         4'h6: pairOf = {3'h6, 3'h5};
         4'h7: pairOf = {3'h0, 3'h2};
         4'h8: pairOf = {3'h0, 3'h3};
         4'h9: pairOf = {3'h0, 3'h4};
         default: pairOf = {3'h0, 3'h5};
      endcase
   endfunction
   // decode; reserved codes leave every switch open
   always_comb begin
      logic [5:0] pr;
      pr = pairOf(inputSelect);
      decNext = '0;
      unique case (bufferSelect)
         BUF_SE_RAW, BUF_SE_UNITY: begin
            decNext.unity = (bufferSelect == BUF_SE_UNITY);
            if (inputSelect[3] == 1'b0) begin
               decNext.pos[inputSelect[2:0]] = 1'b1;
            end else if (inputSelect == SEL_GROUND) begin
               decNext.gnd = 1'b1;
            end else if (inputSelect == SEL_TEMP) begin
               decNext.temp = 1'b1;
            end
         end
         BUF_DI_RAW, BUF_DI_UNITY: begin
            decNext.diff  = 1'b1;
            decNext.unity = (bufferSelect == BUF_DI_UNITY);
            if (inputSelect <= SEL_DIFF_MAX) begin
               decNext.pos[pr[5:3]] = 1'b1;
               decNext.neg[pr[2:0]] = 1'b1;
            end else if (inputSelect == SEL_OFFSET) begin
               decNext.shrt = 1'b1;
            end
         end
         default: decNext = '0;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         decReg <= '0;
      end else begin
         decReg <= decNext;
      end
   end
   assign posSwitch   = decReg.pos;
   assign negSwitch   = decReg.neg;
   assign groundNodes = decReg.gnd;
   assign tempSelect  = decReg.temp;
   assign offsetShort = decReg.shrt;
   assign diffMode    = decReg.diff;
   assign unityBuffer = decReg.unity;
endmodule

// ### verilog/adc_conversion_control.sv
// Purpose: control registers and conversion sequencer of the converter
// Assumes: analog core returns a 13-bit sample and overflow flag on demand
// Notes:   result registers hold the sample captured at each interval end
//
// Summary of operation
// - writing one to conversion_go starts a conversion on the selected input
// - writing one during a conversion restarts it from the beginning
// - go bit reads one until done; hardware clears; writing zero does nothing
// - single mode delivers one result after 5129 cycles
// - repeat mode: first result after 5129 cycles, then every 256
// - temperature sensor doubles every interval
// - reference code {hi,lo}: 00 pin, 01 1.0 V, 10 2.0 V, 11 reserved
// - ref_pin_drive one buffers reference onto the pin; zero frees it
// - single-ended codes 0-7 pins, 1100 ground nodes, 1110 temperature
// - differential codes 0000-1010 fixed pin pairs; 1011-1110 reserved
// - differential code 1111 shorts the inputs for offset calibration
// - reserved codes open all input switches
// - input code is read through the map of the buffer mode
// - buffer codes 000,001,100,101 decoded; others reserved
// - reset selects the internal 2.0 V reference
// - result is 13-bit two's complement over high and low bytes
// - reading the high byte latches the low bits of the same sample
// - overflow flag marks the current sample invalid
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter int FIRST_COUNT  = FIRST_CYCLES,  // first interval
   parameter int REPEAT_COUNT = REPEAT_CYCLES  // later intervals
)(
   input  wire logic        clk_sys,      // system clock
   input  wire logic        rst,          // sync reset, high
   input  wire logic [11:0] regAddr,      // register address
   input  wire logic [7:0]  regWdata,     // write data
   input  wire logic        regWrite,     // write strobe
   input  wire logic        regRead,      // read strobe
   output logic [7:0]       regRdata,     // read data, next cycle
   input  wire logic [12:0] coreSample,   // sample from analog core
   input  wire logic        coreOverflow, // core overflow
   output logic             coreRun,      // core converting
   output logic             sampleStrobe, // result captured
   output logic [1:0]       refLevel,     // reference code
   output logic             refPinDrive,  // drive reference pin
   output logic [7:0]       posSwitch,    // positive input switches
   output logic [7:0]       negSwitch,    // negative input switches
   output logic             groundNodes,  // ground pins 1 and 2
   output logic             tempSelect,   // temperature sensor
   output logic             offsetShort,  // inputs shorted
   output logic             diffMode,     // differential path
   output logic             unityBuffer   // input buffer on
);
   // ********************************
   // elaboration checks
   // ********************************
   // doubled first load must still fit the counter
   if (FIRST_COUNT < 2 || 2 * FIRST_COUNT >= (1 << COUNT_W) || REPEAT_COUNT < 2
       || REPEAT_COUNT > FIRST_COUNT) begin : gen_bad_counts
      $error("adc_conversion_control: interval counts out of range");
   end
   // interval timing: a go write loads the first count less one, the counter
   // steps down once per clock, and the edge after it reads zero captures the
   // sample and raises sampleStrobe, so a first result lands FIRST_COUNT
   // cycles after the write is taken; repeat mode reloads at each capture.
   // the temperature sensor doubles both loads, which is why the counter
   // carries one more bit than the plain first interval needs.
   // a restart simply reloads; one landing on the capture edge still stores that sample, but without sampleStrobe.
   localparam logic [COUNT_W-1:0] FIRST_LOAD  = COUNT_W'(FIRST_COUNT - 1);
   localparam logic [COUNT_W-1:0] REPEAT_LOAD = COUNT_W'(REPEAT_COUNT - 1);
   localparam logic [COUNT_W-1:0] FIRST_LOAD2 = COUNT_W'(2 * FIRST_COUNT - 1);
   localparam logic [COUNT_W-1:0] REPEAT_LD2  = COUNT_W'(2 * REPEAT_COUNT - 1);

   typedef enum logic [1:0] {
      IDLE   = 2'b00,
      FIRST  = 2'b01,
      REPEAT = 2'b10
   } seq_t;

   typedef struct packed {
      logic [7:0]         ctl0;
      logic [7:0]         ctl1;
      seq_t               seq;
      logic [COUNT_W-1:0] count;
      logic [12:0]        sample;
      logic               ovf;
      logic [4:0]         lowLatch;
      logic               ovfLatch;
      logic [7:0]         rdata;
      logic               strobe;
   } state_t;
   state_t stReg, stNext;

   logic goWrite;
   logic seMode;
   logic isTemp;
   logic startTemp;
   logic intervalEnd;
   assign goWrite = regWrite && regAddr == ADDR_CTL_PRIMARY && regWdata[BIT_GO];
   // reserved buffer codes open every switch, so they never count as temperature
   assign seMode  = stReg.ctl1[BUF_W-1:0] inside {BUF_SE_RAW, BUF_SE_UNITY};
   assign isTemp  = seMode && stReg.ctl0[SEL_W-1:0] == SEL_TEMP;
   // a go write may select the sensor in the same byte; judge by the new code
   assign startTemp   = seMode && regWdata[SEL_W-1:0] == SEL_TEMP;
   assign intervalEnd = stReg.seq != IDLE && stReg.count == '0;

   // ********************************
   // sequencer and registers
   // ********************************
   always_comb begin
      stNext = stReg;
      stNext.strobe = 1'b0;
      if (stReg.seq != IDLE) begin
         stNext.count = stReg.count - COUNT_W'(1);
      end
      // interval end: capture and go on or stop
      if (intervalEnd) begin
         stNext.sample = coreSample;
         stNext.ovf    = coreOverflow;
         stNext.strobe = 1'b1;
         if (stReg.ctl0[BIT_REPEAT]) begin
            stNext.seq   = REPEAT;
            stNext.count = isTemp ? REPEAT_LD2 : REPEAT_LOAD;
         end else begin
            stNext.seq = IDLE;
            stNext.ctl0[BIT_GO] = 1'b0;
         end
      end
      // software writes, go bit never cleared by software
      if (regWrite && regAddr == ADDR_CTL_PRIMARY) begin
         stNext.ctl0[BIT_GO-1:0] = regWdata[BIT_GO-1:0];
      end
      if (regWrite && regAddr == ADDR_CTL_SECONDARY) begin
         stNext.ctl1 = regWdata;
      end
      if (goWrite) begin
         stNext.ctl0[BIT_GO] = 1'b1;
         stNext.seq   = FIRST;
         stNext.count = startTemp ? FIRST_LOAD2 : FIRST_LOAD;
         stNext.strobe = 1'b0;
      end
      // read path; high read latches the low bits
      stNext.rdata = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            ADDR_CTL_PRIMARY:   stNext.rdata = stReg.ctl0;
            ADDR_CTL_SECONDARY: stNext.rdata = stReg.ctl1;
            ADDR_RESULT_HIGH: begin
               stNext.rdata    = stReg.sample[12:5];
               stNext.lowLatch = stReg.sample[4:0];
               stNext.ovfLatch = stReg.ovf;
            end
            ADDR_RESULT_LOW: stNext.rdata = {stReg.lowLatch, 2'b00, stReg.ovfLatch};
            default: stNext.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stReg       <= '0;
         stReg.ctl0  <= RESET_PRIMARY;
         stReg.ctl1  <= RESET_SECONDARY;
         stReg.seq   <= IDLE;
      end else begin
         stReg <= stNext;
      end
   end

   // ********************************
   // outputs, all from flip-flops
   // ********************************
   assign regRdata     = stReg.rdata;
   // go bit is high exactly while a sequence runs, so it doubles as the run flag
   assign coreRun      = stReg.ctl0[BIT_GO];
   assign sampleStrobe = stReg.strobe;
   // reference code read straight from the two register bits
   assign refLevel     = {stReg.ctl1[BIT_REF_HI], stReg.ctl0[BIT_REF_LO]};
   assign refPinDrive  = stReg.ctl0[BIT_REF_PIN];

   // input switches decoded one cycle behind the register bits
   adc_input_decode u_decode (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .inputSelect  (stReg.ctl0[SEL_W-1:0]),
      .bufferSelect (stReg.ctl1[BUF_W-1:0]),
      .posSwitch    (posSwitch),
      .negSwitch    (negSwitch),
      .groundNodes  (groundNodes),
      .tempSelect   (tempSelect),
      .offsetShort  (offsetShort),
      .diffMode     (diffMode),
      .unityBuffer  (unityBuffer)
   );

   // ********************************
   // checks
   // ********************************
   chk_go_starts: assert property (@(posedge clk_sys) disable iff (rst)
      goWrite |=> coreRun && stReg.ctl0[BIT_GO])
      else $error("go write did not start conversion");
   chk_restart_reload: assert property (@(posedge clk_sys) disable iff (rst)
      goWrite && !startTemp |=> stReg.count == FIRST_LOAD)
      else $error("restart did not reload count");
   chk_zero_ignored: assert property (@(posedge clk_sys) disable iff (rst)
      regWrite && regAddr == ADDR_CTL_PRIMARY && !regWdata[BIT_GO] && coreRun
      && !intervalEnd |=> stReg.ctl0[BIT_GO])
      else $error("software zero cleared go");
   chk_single_done: assert property (@(posedge clk_sys) disable iff (rst)
      intervalEnd && !stReg.ctl0[BIT_REPEAT] && !goWrite |=> !coreRun && sampleStrobe)
      else $error("single conversion did not end");
   chk_repeat_reload: assert property (@(posedge clk_sys) disable iff (rst)
      intervalEnd && stReg.ctl0[BIT_REPEAT] && !goWrite && !isTemp
      |=> stReg.count == REPEAT_LOAD)
      else $error("repeat interval wrong");
   chk_temp_double: assert property (@(posedge clk_sys) disable iff (rst)
      goWrite && startTemp |=> stReg.count == FIRST_LOAD2)
      else $error("temperature interval not doubled");
   chk_ref_code: assert property (@(posedge clk_sys) disable iff (rst)
      regWrite && regAddr == ADDR_CTL_SECONDARY |=> refLevel[1] == $past(regWdata[BIT_REF_HI]))
      else $error("reference high bit not applied");
   chk_high_latch: assert property (@(posedge clk_sys) disable iff (rst)
      regRead && regAddr == ADDR_RESULT_HIGH && !intervalEnd
      |=> stReg.lowLatch == stReg.sample[4:0])
      else $error("low bits not latched");
   cov_single: cover property (@(posedge clk_sys) intervalEnd && !stReg.ctl0[BIT_REPEAT]);
   cov_repeat: cover property (@(posedge clk_sys) stReg.seq == REPEAT && intervalEnd);
   cov_restart: cover property (@(posedge clk_sys) goWrite && coreRun);
   cov_temp_start: cover property (@(posedge clk_sys) goWrite && startTemp);
   cov_high_read: cover property (@(posedge clk_sys) regRead && regAddr == ADDR_RESULT_HIGH);
   // go bit and sequencer state must never drift apart
   chk_run_matches: assert property (@(posedge clk_sys) disable iff (rst)
      coreRun == (stReg.seq != IDLE))
      else $error("go bit and sequencer disagree");
   chk_repeat_runs: assert property (@(posedge clk_sys) disable iff (rst)
      intervalEnd && stReg.ctl0[BIT_REPEAT] && !goWrite |=> coreRun && stReg.seq == REPEAT)
      else $error("repeat mode stopped early");
   // intervals are at least two cycles, so captures never touch
   chk_strobe_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      sampleStrobe |=> !sampleStrobe)
      else $error("capture pulse longer than one cycle");
   chk_ref_low: assert property (@(posedge clk_sys) disable iff (rst)
      regWrite && regAddr == ADDR_CTL_PRIMARY |=> refLevel[0] == $past(regWdata[BIT_REF_LO]))
      else $error("reference low bit not applied");
   chk_pin_drive: assert property (@(posedge clk_sys) disable iff (rst)
      regWrite && regAddr == ADDR_CTL_PRIMARY |=> refPinDrive == $past(regWdata[BIT_REF_PIN]))
      else $error("reference pin drive not applied");
   chk_sample_take: assert property (@(posedge clk_sys) disable iff (rst)
      intervalEnd |=> stReg.sample == $past(coreSample) && stReg.ovf == $past(coreOverflow))
      else $error("sample not captured at interval end");
   // latch only moves on a high read, never together with a low read
   chk_low_format: assert property (@(posedge clk_sys) disable iff (rst)
      regRead && regAddr == ADDR_RESULT_LOW
      |=> regRdata == {stReg.lowLatch, 2'b00, stReg.ovfLatch})
      else $error("low byte layout wrong");
endmodule

// ### verification/adc_core_model.sv
// Purpose: behavioural analog core facing the converter control block
// Assumes: one sample held from one capture to the next
// Notes:   an idle core shows the inverse of its held value, never a stale one
`timescale 1ns/1ps
module adc_core_model (
   input  wire logic        clk_sys,      // system clock
   input  wire logic        rst,          // sync reset, high
   input  wire logic [12:0] seedVal,      // first sample after reset
   input  wire logic        coreRun,      // core converting
   input  wire logic        sampleStrobe, // result taken
   output logic [12:0]      coreSample,   // sample to the control block
   output logic             coreOverflow  // overflow of that sample
);
   // ****************************************
   // sample source
   // ****************************************
   logic [12:0] heldReg;
   // step only after a capture, so the value taken is never in doubt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         heldReg <= seedVal;
      end else if (sampleStrobe) begin
         heldReg <= heldReg + 13'h0B3D;
      end
   end
   // idle core: inverted, so a design that samples late is caught
   assign coreSample   = coreRun ? heldReg : ~heldReg;
   assign coreOverflow = coreRun ? heldReg[3] : ~heldReg[3];
endmodule

// ### verification/test_adc_conversion_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: short interval counts; one-cycle register strobes
// Notes:   samples come from the behavioural core model
`timescale 1ns/1ps
module test_adc_conversion_control
   import adc_ctrl_pkg::*;
;
   // ****************************************
   // signals and instances
   // ****************************************
   localparam int FC = 20; // short first interval
   localparam int RC = 8;  // short repeat interval
   localparam logic [7:0] PIN_SET = 8'hFF; // pins bonded in the modelled package
   logic        clk_sys  = 1'b0;
   logic        rst      = 1'b1;
   logic [11:0] regAddr  = 12'h000;
   logic [7:0]  regWdata = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead  = 1'b0;
   logic [12:0] seedVal  = 13'h0000;
   logic [31:0] lfsr     = 32'hA118AC5D;
   logic [7:0]  regRdata, pos, neg, d;
   logic [12:0] coreSample;
   logic        coreOverflow, coreRun, sampleStrobe, refPinDrive;
   logic        groundNodes, tempSelect, offsetShort, diffMode, unityBuffer;
   logic [1:0]  refLevel;
   logic [13:0] capReg, exh;
   int          mismatches = 0, compares = 0, cyc = 0, n;
   adc_conversion_control #(.FIRST_COUNT(FC), .REPEAT_COUNT(RC)) u_adc_conversion_control (
      .clk_sys, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .coreSample, .coreOverflow, .coreRun, .sampleStrobe, .refLevel, .refPinDrive,
      .posSwitch(pos), .negSwitch(neg), .groundNodes, .tempSelect, .offsetShort,
      .diffMode, .unityBuffer);
   adc_core_model u_adc_core_model (
      .clk_sys, .rst, .seedVal, .coreRun, .sampleStrobe, .coreSample, .coreOverflow);
   always #20 clk_sys = ~clk_sys;
   // cycle count doubles as the hang limit
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   // what the block should have captured, undoing the idle inversion
   always @(posedge clk_sys) begin
      if (sampleStrobe) begin
         capReg <= coreRun ? {coreOverflow, coreSample} : ~{coreOverflow, coreSample};
      end
   end
   // ****************************************
   // tasks and expectations
   // ****************************************
   function automatic logic [31:0] nextRand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // {pos, neg, ground, temp, offset, diff, unity}
   function automatic logic [20:0] expDec(logic [2:0] b, logic [3:0] c);
      logic [43:0] pt;
      logic [43:0] nt;
      logic [20:0] r;
      pt = 44'h00006531420;
      nt = 44'h54325420531;
      r = {18'h0, b[2], b[0]};
      if (!b[2] && c < 4'h8) r[20:13] = 8'h01 << c;
      if (!b[2] && c == SEL_GROUND) r[4] = 1'b1;
      if (!b[2] && c == SEL_TEMP) r[3] = 1'b1;
      if (b[2] && c <= SEL_DIFF_MAX) r[20:5] = {8'h01 << pt[c*4+:4], 8'h01 << nt[c*4+:4]};
      if (b[2] && c == SEL_OFFSET) r[2] = 1'b1;
      return r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 v = regRdata;
   endtask
   // edges until the capture pulse, or lim if none comes
   task automatic ws(input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk_sys);
         #1 k++;
      end while (sampleStrobe !== 1'b1 && k < lim);
   endtask
   // secondary reserved bits always written as zero
   task automatic decChk(input logic [2:0] b, input logic [3:0] c);
      logic [20:0] e;
      e = expDec(b, c);
      if (((e[20:13] | e[12:5]) & ~PIN_SET) != 8'h00) return;
      wr(ADDR_CTL_SECONDARY, {1'b1, 4'h0, b});
      wr(ADDR_CTL_PRIMARY, {4'h0, c});
      repeat (2) @(posedge clk_sys);
      #1;
      if (b[2] && c == SEL_OFFSET) chk("offset", 1, 32'(offsetShort));
      else chk("decode", 32'(e), 32'({pos, neg, groundNodes, tempSelect,
         offsetShort, diffMode, unityBuffer}));
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      seedVal = lfsr[12:0];
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(ADDR_CTL_PRIMARY, d);
      chk("primary", RESET_PRIMARY, d);
      rd(ADDR_CTL_SECONDARY, d);
      chk("secondary", RESET_SECONDARY, d);
      chk("refLevel", REF_2V0, refLevel);
      rd(12'hF74, d);
      chk("unmapped", 0, d);
      // every reference code, pin drive off whenever the pin is the source
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 2; p++) begin
            if (c == 0 && p == 1) continue;
            wr(ADDR_CTL_SECONDARY, {c[1], 7'h00});
            wr(ADDR_CTL_PRIMARY, {1'b0, c[0], p[0], 5'h00});
            rd(ADDR_CTL_PRIMARY, d);
            chk("refLevel", c, refLevel);
            chk("refPinDrive", p, refPinDrive);
         end
      end
      for (int b = 0; b < 4; b++) begin
         for (int c = 0; c < 16; c++) decChk({b[1], 1'b0, b[0]}, c[3:0]);
      end
      // random back-to-back mode and input changes
      repeat (16) begin
         lfsr = nextRand(lfsr);
         decChk({lfsr[1], 1'b0, lfsr[0]}, lfsr[5:2]);
      end
      // single shot with an ignored zero write and a restart
      wr(ADDR_CTL_PRIMARY, 8'h80);
      rd(ADDR_CTL_PRIMARY, d);
      chk("go", 1, d[7]);
      chk("coreRun", 1, coreRun);
      wr(ADDR_CTL_PRIMARY, 8'h00);
      rd(ADDR_CTL_PRIMARY, d);
      chk("go", 1, d[7]);
      wr(ADDR_CTL_PRIMARY, 8'h80);
      ws(2 * FC, n);
      chk("first", 1, n == FC || n == FC + 1);
      rd(ADDR_CTL_PRIMARY, d);
      chk("go", 0, d[7]);
      ws(2 * FC, n);
      chk("single", 0, sampleStrobe);
      // repeat mode, then the high read must pin the low byte
      wr(ADDR_CTL_PRIMARY, 8'h90);
      ws(2 * FC, n);
      chk("first", 1, n == FC || n == FC + 1);
      for (int k = 0; k < 2; k++) begin
         ws(4 * RC, n);
         chk("period", RC, n);
      end
      rd(ADDR_RESULT_HIGH, d);
      exh = capReg;
      chk("high", exh[12:5], d);
      repeat (RC + 2) @(posedge clk_sys);
      rd(ADDR_RESULT_LOW, d);
      chk("low", {exh[4:0], 2'b00, exh[13]}, d);
      wr(ADDR_CTL_PRIMARY, 8'h00);
      ws(4 * RC, n);
      ws(4 * RC, n);
      chk("stopped", 0, {sampleStrobe, coreRun});
      // temperature sensor doubles both intervals
      wr(ADDR_CTL_SECONDARY, 8'h80);
      wr(ADDR_CTL_PRIMARY, {4'h9, SEL_TEMP});
      ws(4 * FC, n);
      chk("tempFirst", 1, n == 2 * FC || n == 2 * FC + 1);
      ws(8 * RC, n);
      chk("tempPeriod", 2 * RC, n);
      wr(ADDR_CTL_PRIMARY, SEL_TEMP);
      ws(8 * RC, n);
      ws(8 * RC, n);
      chk("stopped", 0, {sampleStrobe, coreRun});
      give_verdict();
   end
endmodule
